// File: verilog/spi_command_port_pkg.sv
package spi_command_port_pkg;
    // Register offsets
    localparam logic [5:0] ADDR_MODE = 6'h00;
    localparam logic [5:0] ADDR_MODE_CTRL = 6'h01;
    localparam logic [5:0] ADDR_FIFO_PORT = 6'h05;
    localparam logic [5:0] ADDR_IDENTITY = 6'h06;
    localparam logic [5:0] ADDR_GP_CTRL = 6'h0B;

    // Values after reset
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_MODE_CTRL = 8'h00;
    localparam logic [7:0] RST_GP_CTRL = 8'h00;
    localparam logic [31:0] RST_IDENTITY = 32'h00000000;

    // Field positions
    localparam int FIFO_MODE_SELECT_BIT = 0;
    localparam int GP_SEL_LSB = 2;
    localparam int GP_SEL_MSB = 5;
    localparam int MODE_EMPTY_BIT = 3;
    localparam int MODE_FULL_BIT = 4;

    // Pin function codes for the general-purpose pin
    localparam logic [3:0] GP_SEL_LOW = 4'h0;
    localparam logic [3:0] GP_SEL_FIFO_EMPTY = 4'h1;
    localparam logic [3:0] GP_SEL_FIFO_FULL = 4'h2;
    localparam logic [3:0] GP_SEL_SERIAL_OUT = 4'h6;

    // Strobe nibbles and full deep-sleep bytes
    localparam logic [3:0] STB_SLEEP = 4'h8;
    localparam logic [3:0] STB_IDLE = 4'h9;
    localparam logic [3:0] STB_STANDBY = 4'hA;
    localparam logic [3:0] STB_PLL = 4'hB;
    localparam logic [3:0] STB_TX = 4'hD;
    localparam logic [3:0] STB_FIFO_PTR_RST = 4'hE;
    localparam logic [7:0] STB_DEEP_TRISTATE = 8'h88;
    localparam logic [7:0] STB_DEEP_PULLUP = 8'h8B;

    // Serial framing
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_NIBBLE = 3'h3;

    // Transmit pacing: the time to send one byte and its cycle count at 200 MHz
    localparam int CLOCK_PERIOD_PS = 5000;
    localparam int TX_BYTE_TIME_NS = 40;
    localparam int TX_BYTE_CYCLES = (TX_BYTE_TIME_NS * 1000) / CLOCK_PERIOD_PS;

    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 64;

    // Operating states, Gray-coded along standby, pll, tx
    typedef enum logic [2:0] {
        ST_STANDBY = 3'h0,
        ST_PLL = 3'h1,
        ST_TX = 3'h3,
        ST_IDLE = 3'h2,
        ST_SLEEP = 3'h6,
        ST_DEEP_SLEEP = 3'h7
    } op_state_t;
endpackage : spi_command_port_pkg

// File: verilog/byte_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    input wire logic clock,
    input wire logic ce,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic push;
    logic pop;

    // Extra pointer bit tells full from empty; depth must be a power of two
    assign in_ready = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign out_data = mem[rd_ptr_r[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers; flush drops everything queued
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else if (ce) begin
            if (flush) begin
                wr_ptr_r <= '0;
                rd_ptr_r <= '0;
            end else begin
                if (push) begin
                    wr_ptr_r <= wr_ptr_r + 1'b1;
                end
                if (pop) begin
                    rd_ptr_r <= rd_ptr_r + 1'b1;
                end
            end
        end
    end

    // Storage has no reset, only the pointers define contents
    always_ff @(posedge clock) begin
        if (ce && push && !flush) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end
endmodule : byte_fifo
`default_nettype wire

// File: verilog/spi_command_port.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R01] Host keeps serial clock at most 10 Mbps
// [R02] Traffic counts only while chip select low
// [R03] Three-wire mode: shared data pin drives reads
// [R04] Four-wire mode: reads on pin, select 0110
// [R05] Input bit sampled on serial clock rise
// [R06] Read data changes on falling edge
// [R07] Host samples read data on rising edge
// [R08] First bit: zero register, one strobe
// [R09] Second bit: one reads, zero writes
// [R10] Six-bit address, then one data byte
// [R11] Strobe is nibble or byte; chaining allowed
// [R12] Strobe nibbles select state or pointer reset
// [R13] Bytes 88h/8Bh deep sleep, registers lost
// [R14] All-zero address and data: soft reset
// [R15] Identity word at 06h, four bytes, byte0 first
// [R16] Host raises chip select to end bursts
// [R17] 64-byte FIFO filled by burst at 05h
// [R18] Host sets FIFO mode, fills, then strobes
// [R19] FIFO status selectable onto general pin
// [R20] FIFO transmit returns; direct mode stays
// [R21] Sleep accepts strobes but no FIFO access
// [R22] MSB first; chip select rise drops partials
// [R23] Burst keeps address, advances byte index
module spi_command_port #(
    parameter int FIFO_BYTES = spi_command_port_pkg::FIFO_DEPTH,
    parameter int BYTE_CYCLES = spi_command_port_pkg::TX_BYTE_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic serial_clock,
    input wire logic serial_chip_select_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic general_purpose_pin_one_out,
    output logic general_purpose_pin_one_oe,
    output logic general_purpose_pin_one_pullup,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic [2:0] op_state,
    output logic internal_reset_n
);
    import spi_command_port_pkg::*;

    logic rst_meta_r;
    logic rst_sync_r;
    logic sck_meta_r;
    logic sck_s_r;
    logic sck_d_r;
    logic cs_meta_r;
    logic cs_s_r;
    logic sdi_meta_r;
    logic sdi_s_r;
    logic sck_rise;
    logic sck_fall;
    logic active;
    logic [2:0] bit_cnt_r;
    logic [7:0] sh_in_r;
    logic [7:0] rx_byte;
    logic data_phase_r;
    logic read_r;
    logic [5:0] addr_r;
    logic [1:0] byte_idx_r;
    logic [7:0] sh_out_r;
    logic cmd_zero_r;
    logic byte_done;
    logic nib_done;
    logic cmd_done;
    logic data_done;
    logic [3:0] strobe_nib;
    logic [5:0] rd_addr;
    logic [1:0] rd_idx;
    logic [7:0] rd_val;
    logic [7:0] mode_r;
    logic [7:0] mode_ctrl_r;
    logic [7:0] gp_ctrl_r;
    logic [31:0] identity_r;
    logic [3:0] gp_sel;
    logic fifo_mode;
    logic four_wire;
    logic soft_reset;
    logic deep_entry;
    logic pullup_sel_r;
    op_state_t state_r;
    op_state_t prev_state_r;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_pop;
    logic fifo_flush;
    logic [$clog2(BYTE_CYCLES+1)-1:0] pace_r;

    // Reset release passes two flops; assertion stays asynchronous
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else if (ce) begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Pin synchronisers; logic reads the second stage, plus a third serial clock stage for edges
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sck_meta_r <= 1'b0;
            sck_s_r <= 1'b0;
            sck_d_r <= 1'b0;
            cs_meta_r <= 1'b1;
            cs_s_r <= 1'b1;
            sdi_meta_r <= 1'b0;
            sdi_s_r <= 1'b0;
        end else if (ce) begin
            sck_meta_r <= serial_clock;
            sck_s_r <= sck_meta_r;
            sck_d_r <= sck_s_r;
            cs_meta_r <= serial_chip_select_n;
            cs_s_r <= cs_meta_r;
            sdi_meta_r <= sdio_in;
            sdi_s_r <= sdi_meta_r;
        end
    end

    // Edge finding on the sampled serial clock, gated by chip select
    assign active = !cs_s_r; // [R02]
    assign sck_rise = active && sck_s_r && !sck_d_r; // [R05]
    assign sck_fall = active && !sck_s_r && sck_d_r; // [R06]
    assign rx_byte = {sh_in_r[6:0], sdi_s_r}; // [R22]
    assign byte_done = sck_rise && (bit_cnt_r == BIT_LAST);
    assign cmd_done = byte_done && !data_phase_r;
    assign data_done = byte_done && data_phase_r;
    assign strobe_nib = {sh_in_r[2:0], sdi_s_r};
    // Strobe acts on its fourth bit, so a 4-bit strobe and a byte other than 88h/8Bh behave the same
    assign nib_done = sck_rise && !data_phase_r && (bit_cnt_r == BIT_NIBBLE) && sh_in_r[2]; // [R08] [R11]

    assign fifo_mode = mode_ctrl_r[FIFO_MODE_SELECT_BIT];
    assign gp_sel = gp_ctrl_r[GP_SEL_MSB:GP_SEL_LSB];
    assign four_wire = (gp_sel == GP_SEL_SERIAL_OUT);
    assign soft_reset = data_done && !read_r && cmd_zero_r && (rx_byte == 8'h00); // [R14]
    assign deep_entry = cmd_done && ((rx_byte == STB_DEEP_TRISTATE) || (rx_byte == STB_DEEP_PULLUP)); // [R13]

    // Bit counter and command decode; a rising chip select abandons the access
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            bit_cnt_r <= 3'h0;
            sh_in_r <= 8'h00;
            data_phase_r <= 1'b0;
            read_r <= 1'b0;
            addr_r <= 6'h00;
            byte_idx_r <= 2'h0;
            cmd_zero_r <= 1'b0;
        end else if (ce) begin
            if (!active) begin
                bit_cnt_r <= 3'h0; // [R22]
                data_phase_r <= 1'b0;
                read_r <= 1'b0;
            end else if (sck_rise) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                sh_in_r <= rx_byte; // [R22]
                if (cmd_done && !rx_byte[7]) begin
                    data_phase_r <= 1'b1; // [R08]
                    read_r <= rx_byte[6]; // [R09]
                    addr_r <= rx_byte[5:0]; // [R10]
                    byte_idx_r <= 2'h0;
                    cmd_zero_r <= (rx_byte == 8'h00);
                end else if (data_done) begin
                    byte_idx_r <= byte_idx_r + 2'h1; // [R23]
                    cmd_zero_r <= 1'b0;
                end
            end
        end
    end

    // Read source: next byte of the burst, or byte 0 when the address lands
    assign rd_addr = data_phase_r ? addr_r : rx_byte[5:0];
    assign rd_idx = data_phase_r ? (byte_idx_r + 2'h1) : 2'h0;

    always_comb begin
        rd_val = 8'h00;
        case (rd_addr)
            ADDR_MODE: begin
                rd_val = {mode_r[7:5], !fifo_in_ready, !fifo_out_valid, state_r};
            end
            ADDR_MODE_CTRL: begin
                rd_val = mode_ctrl_r;
            end
            ADDR_IDENTITY: begin
                rd_val = identity_r[{rd_idx, 3'h0} +: 8]; // [R15]
            end
            ADDR_GP_CTRL: begin
                rd_val = gp_ctrl_r;
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    // Output shifter: loaded on the rise that ends a byte, shifted on each fall of a read
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sh_out_r <= 8'h00;
            sdio_out <= 1'b0;
            sdio_oe <= 1'b0;
            general_purpose_pin_one_out <= 1'b0;
            general_purpose_pin_one_oe <= 1'b0;
            general_purpose_pin_one_pullup <= 1'b0;
        end else if (ce) begin
            if (byte_done && ((cmd_done && !rx_byte[7] && rx_byte[6]) || (data_done && read_r))) begin
                sh_out_r <= rd_val; // [R15] [R23]
            end else if (sck_fall && read_r) begin
                sh_out_r <= {sh_out_r[6:0], 1'b0}; // [R06]
            end
            if (sck_fall && read_r) begin
                sdio_out <= sh_out_r[7]; // [R06] [R22]
            end
            // Shared pin turns round only after the address byte is in
            sdio_oe <= active && read_r && !four_wire; // [R03]
            general_purpose_pin_one_pullup <= (state_r == ST_DEEP_SLEEP) && pullup_sel_r; // [R13]
            if (state_r == ST_DEEP_SLEEP) begin
                general_purpose_pin_one_oe <= 1'b0; // [R13]
                general_purpose_pin_one_out <= 1'b0;
            end else begin
                general_purpose_pin_one_oe <= 1'b1;
                case (gp_sel)
                    GP_SEL_SERIAL_OUT: begin
                        general_purpose_pin_one_out <= (sck_fall && read_r) ? sh_out_r[7] : sdio_out; // [R04]
                    end
                    GP_SEL_FIFO_EMPTY: begin
                        general_purpose_pin_one_out <= !fifo_out_valid; // [R19]
                    end
                    GP_SEL_FIFO_FULL: begin
                        general_purpose_pin_one_out <= !fifo_in_ready; // [R19]
                    end
                    default: begin
                        general_purpose_pin_one_out <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Register writes; soft reset and deep sleep both return the defaults
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            mode_r <= RST_MODE;
            mode_ctrl_r <= RST_MODE_CTRL;
            gp_ctrl_r <= RST_GP_CTRL;
            identity_r <= RST_IDENTITY;
        end else if (ce) begin
            if (soft_reset || deep_entry) begin
                mode_r <= RST_MODE; // [R13] [R14]
                mode_ctrl_r <= RST_MODE_CTRL;
                gp_ctrl_r <= RST_GP_CTRL;
                identity_r <= RST_IDENTITY;
            end else if (data_done && !read_r) begin
                case (addr_r)
                    ADDR_MODE: begin
                        mode_r <= rx_byte;
                    end
                    ADDR_MODE_CTRL: begin
                        mode_ctrl_r <= rx_byte; // [R18]
                    end
                    ADDR_IDENTITY: begin
                        identity_r[{byte_idx_r, 3'h0} +: 8] <= rx_byte; // [R15] [R23]
                    end
                    ADDR_GP_CTRL: begin
                        gp_ctrl_r <= rx_byte; // [R04] [R19]
                    end
                    default: begin
                        mode_r <= mode_r;
                    end
                endcase
            end
        end
    end

    // Internal reset pulse, one cycle low after an all-zero write
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            internal_reset_n <= 1'b0;
        end else if (ce) begin
            internal_reset_n <= !soft_reset; // [R14]
        end
    end

    // Operating state: strobes move it, FIFO transmit returns on its own
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            state_r <= ST_STANDBY;
            prev_state_r <= ST_STANDBY;
            pullup_sel_r <= 1'b0;
        end else if (ce) begin
            if (soft_reset) begin
                state_r <= ST_STANDBY; // [R14]
            end else if (deep_entry) begin
                state_r <= ST_DEEP_SLEEP; // [R13]
                pullup_sel_r <= (rx_byte == STB_DEEP_PULLUP);
            end else if (nib_done) begin
                case (strobe_nib)
                    STB_SLEEP: begin
                        state_r <= ST_SLEEP; // [R12] [R21]
                    end
                    STB_IDLE: begin
                        state_r <= ST_IDLE; // [R12]
                    end
                    STB_STANDBY: begin
                        state_r <= ST_STANDBY; // [R12]
                    end
                    STB_PLL: begin
                        state_r <= ST_PLL; // [R12]
                    end
                    STB_TX: begin
                        if (state_r != ST_TX) begin
                            prev_state_r <= state_r; // [R20]
                        end
                        state_r <= ST_TX; // [R12]
                    end
                    default: begin
                        state_r <= state_r;
                    end
                endcase
            end else if (state_r == ST_TX && fifo_mode && !fifo_out_valid && pace_r == '0) begin
                state_r <= prev_state_r; // [R20]
            end
        end
    end

    // FIFO may not be written in either sleep state
    assign fifo_in_valid = data_done && !read_r && (addr_r == ADDR_FIFO_PORT)
        && (state_r != ST_SLEEP) && (state_r != ST_DEEP_SLEEP); // [R17] [R21]
    assign fifo_flush = soft_reset || deep_entry || (nib_done && strobe_nib == STB_FIFO_PTR_RST); // [R12]
    assign fifo_pop = (state_r == ST_TX) && fifo_mode && fifo_out_valid && (pace_r == '0);

    // A byte that lands on a full FIFO is dropped; the host sees full on the pin
    byte_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_BYTES)
    ) u_tx_fifo (
        .clock(clock),
        .ce(ce),
        .rst_n(rst_sync_r),
        .flush(fifo_flush),
        .in_valid(fifo_in_valid),
        .in_data(rx_byte),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_pop)
    ); // [R17]

    // Transmit pacing stalls the FIFO drain, so it fills while the link is slow
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            pace_r <= '0;
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
        end else if (ce) begin
            tx_valid <= fifo_pop; // [R20]
            if (fifo_pop) begin
                tx_data <= fifo_out_data;
                pace_r <= ($clog2(BYTE_CYCLES+1))'(BYTE_CYCLES - 1);
            end else if (pace_r != '0) begin
                pace_r <= pace_r - 1'b1;
            end
        end
    end

    // State shown outside as a registered copy
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            op_state <= ST_STANDBY;
        end else if (ce) begin
            op_state <= state_r;
        end
    end
endmodule : spi_command_port
`default_nettype wire

// File: tb/spi_command_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
module spi_command_port_properties
    import spi_command_port_pkg::*;
#(
    parameter int FIFO_BYTES = 64,
    parameter int BYTE_CYCLES = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic serial_clock,
    input wire logic serial_chip_select_n,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic general_purpose_pin_one_oe,
    input wire logic general_purpose_pin_one_pullup,
    input wire logic tx_valid,
    input wire logic [2:0] op_state,
    input wire logic internal_reset_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // Soft reset pulse is exactly one cycle wide
    sequence back_high_s;
        ##1 internal_reset_n [*2];
    endsequence
    // Deselected frame: synchroniser delay is well inside eight cycles
    sequence cs_idle_s;
        serial_chip_select_n [*8];
    endsequence
    rst_pulse_a: assert property ($fell(internal_reset_n) |-> back_high_s)
        else $error("soft reset pulse not one cycle");
    rst_standby_a: assert property ($rose(internal_reset_n) |-> ##[0:2] (op_state == ST_STANDBY))
        else $error("no standby after reset");
    cs_quiet_a: assert property (cs_idle_s |-> !sdio_oe)
        else $error("data pin driven while deselected");
    oe_frame_a: assert property ($rose(sdio_oe) |-> !serial_chip_select_n)
        else $error("data pin driven outside a frame");
    out_on_fall_a: assert property ((sdio_oe && $past(sdio_oe) && $changed(sdio_out)) |-> !serial_clock)
        else $error("read bit moved while serial clock high");
    tx_gap_a: assert property (tx_valid |=> !tx_valid [*7])
        else $error("transmit bytes closer than pacing");
    deep_oe_a: assert property ((op_state == ST_DEEP_SLEEP) |-> !general_purpose_pin_one_oe)
        else $error("pin driven in deep sleep");
    pullup_deep_a: assert property (general_purpose_pin_one_pullup |-> (op_state == ST_DEEP_SLEEP))
        else $error("pull-up outside deep sleep");
endmodule : spi_command_port_properties
`default_nettype wire

// File: tb/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host master; its serial clock stands low outside frames
module spi_host_model (
    output logic serial_clock,
    output logic serial_chip_select_n,
    output logic host_bit,
    output logic host_oe,
    input wire logic line_in
);
    // Idle bus at time zero
    initial begin
        serial_clock = 1'b0;
        serial_chip_select_n = 1'b1;
        host_bit = 1'b0;
        host_oe = 1'b0;
    end
    // Chip select low for the whole access
    task automatic open_frame();
        serial_chip_select_n = 1'b0;
        #80;
    endtask : open_frame
    // Raising chip select ends a burst; the line is released
    task automatic close_frame();
        #80;
        serial_chip_select_n = 1'b1;
        host_oe = 1'b0;
        #400;
    endtask : close_frame
    // 160 ns period stays under 10 Mbps; MSB first; read bit taken on rise
    task automatic shift(input logic [7:0] tx, input int nbits, input logic drive, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            host_oe = drive;
            host_bit = tx[7-i];
            #80;
            serial_clock = 1'b1;
            rx = {rx[6:0], line_in};
            #80;
            serial_clock = 1'b0;
        end
    endtask : shift
endmodule : spi_host_model
`default_nettype wire

// File: tb/spi_command_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module spi_command_port_tb;
    import spi_command_port_pkg::*;
    logic clock, rstn, sck, csn, hbit, hoe, last_v, four_wire, oe_seen, rst_seen;
    logic sdio_out, sdio_oe, gp_out, gp_oe, gp_pu, tx_valid, irst_n;
    logic [7:0] tx_data, rx;
    logic [2:0] op_state;
    logic [7:0] txq[$], dq[$];
    int n_mismatch = 0, checks_done = 0;
    // Shared data wire: device, else host, else a toggling level
    wire logic sdio_line = sdio_oe ? sdio_out : (hoe ? hbit : ~last_v);
    spi_command_port dut_u (.clock(clock), .rstn(rstn), .ce(1'b1), .serial_clock(sck),
        .serial_chip_select_n(csn), .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .general_purpose_pin_one_out(gp_out), .general_purpose_pin_one_oe(gp_oe),
        .general_purpose_pin_one_pullup(gp_pu), .tx_data(tx_data), .tx_valid(tx_valid),
        .op_state(op_state), .internal_reset_n(irst_n));
    spi_host_model host_u (.serial_clock(sck), .serial_chip_select_n(csn), .host_bit(hbit),
        .host_oe(hoe), .line_in(four_wire ? gp_out : sdio_line));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Monitors: line history, drive, reset pulse, sent bytes
    always @(posedge clock) begin
        last_v <= sdio_line;
        if (sdio_oe) oe_seen <= 1'b1;
        if (!irst_n) rst_seen <= 1'b1;
        if (tx_valid) txq.push_back(tx_data);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // Command byte then nb data bytes from dq, or read into dq
    task automatic frame(input logic [7:0] cmd, input int nb, input logic rd);
        logic [7:0] r;
        @(posedge clock) #1;
        host_u.open_frame();
        host_u.shift(cmd, 8, 1'b1, r);
        for (int i = 0; i < nb; i++) begin
            host_u.shift(rd ? 8'h00 : dq[i], 8, !rd, r);
            if (rd) dq.push_back(r);
        end
        host_u.close_frame();
    endtask : frame
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        dq = '{d};
        frame({2'b00, a}, 1, 1'b0);
    endtask : wr
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        dq = {};
        frame({2'b01, a}, 1, 1'b1);
        chk(dq[0], e);
    endtask : rd_chk
    // Four-bit strobe, chip select raised right after
    task automatic strobe(input logic [3:0] n);
        @(posedge clock) #1;
        host_u.open_frame();
        host_u.shift({n, 4'h0}, 4, 1'b1, rx);
        host_u.close_frame();
    endtask : strobe
    task automatic wait_st(input logic [2:0] st);
        int k;
        for (k = 0; k < 1000 && op_state !== st; k++) @(posedge clock);
        if (k == 1000) begin
            n_mismatch++;
            test_done();
        end
    endtask : wait_st
    task automatic t_regs();
        rd_chk(ADDR_MODE, 8'h08);
        rd_chk(ADDR_GP_CTRL, RST_GP_CTRL);
        rd_chk(6'h3F, 8'h00);
        wr(ADDR_MODE, 8'hFF);
        rd_chk(ADDR_MODE, 8'hE8);
        wr(ADDR_MODE_CTRL, 8'h5A);
        rd_chk(ADDR_MODE_CTRL, 8'h5A);
        rst_seen = 1'b0;
        wr(ADDR_MODE, 8'h00);
        chk(rst_seen, 1'b1);
        rd_chk(ADDR_MODE_CTRL, RST_MODE_CTRL);
        rd_chk(ADDR_MODE, 8'h08);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_ident();
        dq = '{8'h11, 8'h22, 8'h33, 8'h44};
        frame(8'h06, 4, 1'b0);
        @(posedge clock) #1;
        host_u.open_frame();
        host_u.shift(8'hFF, 3, 1'b1, rx);
        host_u.close_frame();
        oe_seen = 1'b0;
        dq = {};
        frame(8'h46, 4, 1'b1);
        chk({dq[3], dq[2], dq[1], dq[0]}, 32'h44332211);
        chk(oe_seen, 1'b1);
        wr(ADDR_GP_CTRL, 8'h18);
        four_wire = 1'b1;
        oe_seen = 1'b0;
        dq = {};
        frame(8'h46, 4, 1'b1);
        chk({dq[3], dq[2], dq[1], dq[0]}, 32'h44332211);
        chk(oe_seen, 1'b0);
        four_wire = 1'b0;
        wr(ADDR_GP_CTRL, 8'h00);
        $display("t_ident done");
    endtask : t_ident
    task automatic t_strobe();
        logic [3:0] nib[4] = '{STB_SLEEP, STB_IDLE, STB_STANDBY, STB_PLL};
        logic [2:0] st[4] = '{ST_SLEEP, ST_IDLE, ST_STANDBY, ST_PLL};
        for (int i = 0; i < 4; i++) begin
            strobe(nib[i]);
            chk(op_state, st[i]);
        end
        strobe(STB_SLEEP);
        wr(ADDR_FIFO_PORT, 8'h77);
        strobe(STB_STANDBY);
        rd_chk(ADDR_MODE, 8'h08);
        dq = '{{STB_IDLE, 4'h5}};
        frame({STB_PLL, 4'hC}, 1, 1'b0);
        chk(op_state, ST_IDLE);
        strobe(STB_STANDBY);
        $display("t_strobe done");
    endtask : t_strobe
    task automatic t_fifo();
        wr(ADDR_MODE_CTRL, 8'h01);
        dq = {};
        for (int i = 0; i < 65; i++) dq.push_back(i[7:0]);
        frame(8'h05, 65, 1'b0);
        rd_chk(ADDR_MODE, 8'h10);
        wr(ADDR_GP_CTRL, 8'h08);
        chk(gp_out, 1'b1);
        txq = {};
        strobe(STB_TX);
        wait_st(ST_STANDBY);
        chk(txq.size(), 64);
        for (int i = 0; i < 64; i++) chk(txq[i], i);
        wr(ADDR_GP_CTRL, 8'h04);
        chk(gp_out, 1'b1);
        dq = '{8'hAA, 8'h55};
        frame(8'h05, 2, 1'b0);
        chk(gp_out, 1'b0);
        strobe(STB_FIFO_PTR_RST);
        chk(gp_out, 1'b1);
        wr(ADDR_MODE_CTRL, 8'h00);
        strobe(STB_TX);
        repeat (100) @(posedge clock);
        chk(op_state, ST_TX);
        strobe(STB_STANDBY);
        $display("t_fifo done");
    endtask : t_fifo
    task automatic t_deep();
        frame(STB_DEEP_PULLUP, 0, 1'b0);
        chk({gp_pu, gp_oe, op_state}, {2'b10, ST_DEEP_SLEEP});
        strobe(STB_IDLE);
        chk({gp_oe, op_state}, {1'b1, ST_IDLE});
        rd_chk(ADDR_GP_CTRL, 8'h00);
        frame(STB_DEEP_TRISTATE, 0, 1'b0);
        chk({gp_pu, gp_oe, op_state}, {2'b00, ST_DEEP_SLEEP});
        strobe(STB_STANDBY);
        $display("t_deep done");
    endtask : t_deep
    initial begin
        rstn = 1'b0;
        four_wire = 1'b0;
        last_v = 1'b0;
        oe_seen = 1'b0;
        rst_seen = 1'b0;
        repeat (4) @(posedge clock);
        #1 rstn = 1'b1;
        repeat (8) @(posedge clock);
        t_regs();
        t_ident();
        t_strobe();
        t_fifo();
        t_deep();
        test_done();
    end
endmodule : spi_command_port_tb
bind spi_command_port spi_command_port_properties #(.FIFO_BYTES(FIFO_BYTES), .BYTE_CYCLES(BYTE_CYCLES)) chk_u (
    .clock(clock), .rstn(rstn), .serial_clock(serial_clock), .serial_chip_select_n(serial_chip_select_n),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .general_purpose_pin_one_oe(general_purpose_pin_one_oe),
    .general_purpose_pin_one_pullup(general_purpose_pin_one_pullup), .tx_valid(tx_valid),
    .op_state(op_state), .internal_reset_n(internal_reset_n));
`default_nettype wire
